// ### core/xfer_pkg.sv
/*
  Package for the displacement move and linked store execution block:
  opcode patterns, sizes, constants and carrier structs.
  Assumes a core that supplies decoded register values and a data memory
  path (cache and MMU) that answers each access with done, carrying any fault.
*/
package xfer_pkg;

  // ****************************************************************
  // Opcode patterns
  // ****************************************************************
  localparam logic [7:0]  OP_STB_DISP  = 8'h80;
  localparam logic [7:0]  OP_STW_DISP  = 8'h81;
  localparam logic [3:0]  OP_STL_DISP  = 4'h1;
  localparam logic [3:0]  OP_LDL_DISP  = 4'h5;
  localparam logic [7:0]  OP_LDB_DISP  = 8'h84;
  localparam logic [7:0]  OP_LDW_DISP  = 8'h85;
  localparam logic [7:0]  OP_PC_EA     = 8'hC7;
  localparam logic [3:0]  OP_SYS_HI    = 4'h0;
  localparam logic [7:0]  OP_ALLOC_LO  = 8'hC3;
  localparam logic [7:0]  OP_COND_LO   = 8'h73;
  localparam logic [7:0]  OP_LINK_LO   = 8'h63;

  // ****************************************************************
  // Address, register index and link reset constants
  // ****************************************************************
  localparam logic [31:0] PC_ALIGN_MASK = 32'hFFFFFFFC;
  localparam logic [31:0] PC_AHEAD      = 32'h00000004;
  localparam logic [3:0]  REG_ZERO      = 4'h0;
  localparam logic        LINK_RESET    = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } size_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEM  = 3'b010,
    ST_WB   = 3'b100
  } state_e;

  typedef struct packed {
    logic        valid;
    logic [15:0] opcode;
    logic [31:0] pc;
    logic        in_delay_slot;
    logic [31:0] rn_value;
    logic [31:0] rm_value;
    logic [31:0] r0_value;
  } issue_s;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        alloc;
    size_e       size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
    logic        tlb_miss;
    logic        tlb_multi_hit;
    logic        tlb_protect;
    logic        addr_error;
    logic        initial_write;
  } mem_rsp_s;

  typedef struct packed {
    logic        tlb_miss;
    logic        tlb_multi_hit;
    logic        tlb_protect;
    logic        addr_error;
    logic        initial_write;
    logic        slot_illegal;
  } exc_s;

  typedef struct packed {
    logic        we;
    logic [3:0]  index;
    logic [31:0] data;
  } wb_s;

endpackage

// ### core/displacement_move_and_linked_store.sv
/*
  Execution unit for displacement loads and stores, the PC-relative
  effective-address op, the allocating store and the linked load /
  conditional store pair with its link reservation flag.
  Assumes the core stalls issue while busy is high, supplies register
  values at issue, and that the memory path answers each request with a
  one-cycle done pulse, carrying any fault flags in that cycle.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Byte store of register zero at Rn plus displacement.
// - Halfword store of register zero at Rn plus twice displacement.
// - Word store of Rm at Rn plus four times displacement.
// - Word load from Rm plus four times displacement into Rn.
// - Byte and halfword loads target register zero, sign-extended.
// - Four-bit displacement zero-extended, scaled by one, two or four.
// - Readers of register zero stall while narrow load is pending.
// - Effective-address op writes register zero, 8-bit disp times four.
// - Result is aligned PC plus four plus scaled displacement.
// - Effective-address op in delay slot raises slot illegal.
// - Allocating store writes register zero at address in Rn.
// - Allocating store miss allocates the line without a fill.
// - Conditional store copies link flag into condition flag first.
// - Conditional store writes only when condition flag is one.
// - Conditional store clears link flag in its issue cycle.
// - Linked load sets link flag and loads word into register zero.
// - Any accepted interrupt or exception clears the link flag.
// - Displacement accesses report TLB and address faults; stores too.
module displacement_move_and_linked_store (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Issue from decode
  input  wire xfer_pkg::issue_s  issue,
  input  wire logic              next_reads_r0,
  input  wire logic              event_accepted,
  output logic                   accepted,
  output logic                   busy,
  output logic                   r0_stall,
  // Data memory path
  output xfer_pkg::mem_req_s     mem_req,
  input  wire xfer_pkg::mem_rsp_s mem_rsp,
  // Results
  output xfer_pkg::wb_s          wb,
  output logic                   t_we,
  output logic                   t_value,
  output xfer_pkg::exc_s         exc,
  output logic                   exc_valid,
  output logic                   link_reservation_flag
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    xfer_pkg::state_e   state;
    xfer_pkg::mem_req_s req;
    logic               is_load;
    logic               sign_ext;
    logic [3:0]         dest;
    logic               narrow_r0;
    logic               is_cond;
    logic               link;
    xfer_pkg::wb_s      wb;
    logic               t_we;
    logic               t_value;
    xfer_pkg::exc_s     exc;
    logic               exc_valid;
  } state_s;

  state_s st;
  state_s next_st;

  logic [15:0] op;
  logic [3:0]  disp4;
  logic [31:0] ld_data;
  logic        mem_fault;
  logic        can_issue;

  assign op        = issue.opcode;
  assign disp4     = op[3:0];
  assign can_issue = (st.state == xfer_pkg::ST_IDLE);
  assign mem_fault = mem_rsp.tlb_miss | mem_rsp.tlb_multi_hit |
                     mem_rsp.tlb_protect | mem_rsp.addr_error |
                     (st.req.write & mem_rsp.initial_write);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st           = st;
    next_st.wb.we     = 1'b0;
    next_st.t_we      = 1'b0;
    next_st.exc_valid = 1'b0;
    next_st.exc       = '0;
    ld_data           = mem_rsp.rdata;
    if (st.sign_ext && st.req.size == xfer_pkg::SIZE_BYTE) begin
      ld_data = {{24{mem_rsp.rdata[7]}}, mem_rsp.rdata[7:0]};
    end else if (st.sign_ext) begin
      ld_data = {{16{mem_rsp.rdata[15]}}, mem_rsp.rdata[15:0]};
    end
    unique case (st.state)
      xfer_pkg::ST_IDLE: begin
        if (issue.valid) begin
          next_st.req.wdata = issue.r0_value;
          next_st.req.alloc = 1'b0;
          next_st.sign_ext  = 1'b0;
          next_st.is_cond   = 1'b0;
          next_st.narrow_r0 = 1'b0;
          next_st.dest      = xfer_pkg::REG_ZERO;
          if (op[15:8] == xfer_pkg::OP_STB_DISP) begin
            next_st.state    = xfer_pkg::ST_MEM;
            next_st.is_load  = 1'b0;
            next_st.req.size = xfer_pkg::SIZE_BYTE;
            next_st.req.addr = issue.rn_value + {28'h0000000, disp4};
          end else if (op[15:8] == xfer_pkg::OP_STW_DISP) begin
            next_st.state    = xfer_pkg::ST_MEM;
            next_st.is_load  = 1'b0;
            next_st.req.size = xfer_pkg::SIZE_HALF;
            next_st.req.addr = issue.rn_value +
                               {27'h0000000, disp4, 1'b0};
          end else if (op[15:12] == xfer_pkg::OP_STL_DISP) begin
            next_st.state     = xfer_pkg::ST_MEM;
            next_st.is_load   = 1'b0;
            next_st.req.size  = xfer_pkg::SIZE_WORD;
            next_st.req.wdata = issue.rm_value;
            next_st.req.addr  = issue.rn_value +
                                {26'h0000000, disp4, 2'b00};
          end else if (op[15:12] == xfer_pkg::OP_LDL_DISP) begin
            next_st.state    = xfer_pkg::ST_MEM;
            next_st.is_load  = 1'b1;
            next_st.dest     = op[11:8];
            next_st.req.size = xfer_pkg::SIZE_WORD;
            next_st.req.addr = issue.rm_value +
                               {26'h0000000, disp4, 2'b00};
          end else if (op[15:8] == xfer_pkg::OP_LDB_DISP) begin
            next_st.state     = xfer_pkg::ST_MEM;
            next_st.is_load   = 1'b1;
            next_st.sign_ext  = 1'b1;
            next_st.narrow_r0 = 1'b1;
            next_st.req.size  = xfer_pkg::SIZE_BYTE;
            next_st.req.addr  = issue.rm_value + {28'h0000000, disp4};
          end else if (op[15:8] == xfer_pkg::OP_LDW_DISP) begin
            next_st.state     = xfer_pkg::ST_MEM;
            next_st.is_load   = 1'b1;
            next_st.sign_ext  = 1'b1;
            next_st.narrow_r0 = 1'b1;
            next_st.req.size  = xfer_pkg::SIZE_HALF;
            next_st.req.addr  = issue.rm_value +
                                {27'h0000000, disp4, 1'b0};
          end else if (op[15:8] == xfer_pkg::OP_PC_EA) begin
            if (issue.in_delay_slot) begin
              next_st.exc.slot_illegal = 1'b1;
              next_st.exc_valid        = 1'b1;
            end else begin
              next_st.wb.we    = 1'b1;
              next_st.wb.index = xfer_pkg::REG_ZERO;
              next_st.wb.data  = (issue.pc & xfer_pkg::PC_ALIGN_MASK) +
                                 xfer_pkg::PC_AHEAD +
                                 {22'h000000, op[7:0], 2'b00};
            end
          end else if (op[15:12] == xfer_pkg::OP_SYS_HI &&
                       op[7:0] == xfer_pkg::OP_ALLOC_LO) begin
            next_st.state     = xfer_pkg::ST_MEM;
            next_st.is_load   = 1'b0;
            next_st.req.alloc = 1'b1;
            next_st.req.size  = xfer_pkg::SIZE_WORD;
            next_st.req.addr  = issue.rn_value;
          end else if (op[15:12] == xfer_pkg::OP_SYS_HI &&
                       op[7:0] == xfer_pkg::OP_COND_LO) begin
            next_st.t_we    = 1'b1;
            next_st.t_value = st.link;
            next_st.link    = 1'b0;
            if (st.link) begin
              next_st.state    = xfer_pkg::ST_MEM;
              next_st.is_load  = 1'b0;
              next_st.is_cond  = 1'b1;
              next_st.req.size = xfer_pkg::SIZE_WORD;
              next_st.req.addr = issue.rn_value;
            end
          end else if (op[15:12] == xfer_pkg::OP_SYS_HI &&
                       op[7:0] == xfer_pkg::OP_LINK_LO) begin
            next_st.state    = xfer_pkg::ST_MEM;
            next_st.is_load  = 1'b1;
            next_st.link     = 1'b1;
            next_st.req.size = xfer_pkg::SIZE_WORD;
            next_st.req.addr = issue.rm_value;
          end
          next_st.req.write = ~next_st.is_load;
          next_st.req.req   = (next_st.state == xfer_pkg::ST_MEM);
        end
      end
      xfer_pkg::ST_MEM: begin
        if (mem_rsp.done) begin
          next_st.req.req = 1'b0;
          next_st.state   = xfer_pkg::ST_IDLE;
          if (mem_fault) begin
            next_st.exc.tlb_miss      = mem_rsp.tlb_miss;
            next_st.exc.tlb_multi_hit = mem_rsp.tlb_multi_hit;
            next_st.exc.tlb_protect   = mem_rsp.tlb_protect;
            next_st.exc.addr_error    = mem_rsp.addr_error;
            next_st.exc.initial_write = st.req.write &
                                        mem_rsp.initial_write;
            next_st.exc_valid         = 1'b1;
          end else if (st.is_load) begin
            next_st.wb.we    = 1'b1;
            next_st.wb.index = st.dest;
            next_st.wb.data  = ld_data;
          end
          next_st.narrow_r0 = 1'b0;
        end
      end
      xfer_pkg::ST_WB: begin
        next_st.state = xfer_pkg::ST_IDLE;
      end
    endcase
    if (event_accepted || next_st.exc_valid) begin
      next_st.link = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      st       <= '0;
      st.state <= xfer_pkg::ST_IDLE;
      st.link  <= xfer_pkg::LINK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign accepted              = issue.valid & can_issue;
  assign busy                  = ~can_issue;
  assign r0_stall              = st.narrow_r0 & next_reads_r0;
  assign mem_req               = st.req;
  assign wb                    = st.wb;
  assign t_we                  = st.t_we;
  assign t_value               = st.t_value;
  assign exc                   = st.exc;
  assign exc_valid             = st.exc_valid;
  assign link_reservation_flag = st.link;

endmodule

// ### test/mem_model.sv
/*
  Behavioural data memory path (cache and MMU) for the transfer block.
  Assumes the block holds each request until the done pulse.
*/
`timescale 1ns/1ps
module mem_model (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // Request and answer
  input  wire xfer_pkg::mem_req_s mem_req,
  output xfer_pkg::mem_rsp_s      mem_rsp,
  // Bench control and record
  input  wire logic [3:0]         delay,
  input  wire logic               fault,
  output xfer_pkg::mem_req_s      last_wr,
  output logic [7:0]              n_writes
);
  // ****
  // Answer after delay; read data is noise outside done
  // ****
  logic [3:0] wait_cnt;
  logic [7:0] noise;
  always_ff @(posedge clock) begin
    mem_rsp <= '0;
    mem_rsp.rdata <= {4{noise}};
    noise <= noise + 8'h35;
    if (rst) begin
      wait_cnt <= 4'h0;
      n_writes <= 8'h00;
      noise <= 8'hA5;
    end else if (mem_req.req && !mem_rsp.done) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= delay) begin
        wait_cnt <= 4'h0;
        mem_rsp.done <= 1'b1;
        mem_rsp.rdata <= ~mem_req.addr;
        mem_rsp.tlb_miss <= fault;
        mem_rsp.initial_write <= fault & mem_req.write;
        // Line written without a fill; faulted writes dropped
        if (mem_req.write && !fault) begin
          last_wr <= mem_req;
          n_writes <= n_writes + 8'h01;
        end
      end
    end
  end
endmodule

// ### test/xfer_checker.sv
/*
  Concurrent checks on the transfer block's ports.
  Assumes it is bound to the block's top module.
*/
`timescale 1ns/1ps
module xfer_checker (
  input wire logic               clock,
  input wire logic               rst,
  input wire xfer_pkg::issue_s   issue,
  input wire logic               next_reads_r0,
  input wire logic               event_accepted,
  input wire logic               accepted,
  input wire logic               busy,
  input wire logic               r0_stall,
  input wire xfer_pkg::mem_req_s mem_req,
  input wire xfer_pkg::mem_rsp_s mem_rsp,
  input wire xfer_pkg::wb_s      wb,
  input wire logic               t_we,
  input wire logic               t_value,
  input wire xfer_pkg::exc_s     exc,
  input wire logic               exc_valid,
  input wire logic               link_reservation_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  xfer_pkg::issue_s prev;
  logic go_ea, go_cond, go_link, go_stb, go_stl, lk;
  always_ff @(posedge clock) prev <= issue;
  assign lk = link_reservation_flag;
  assign go_ea = accepted && issue.opcode[15:8] == xfer_pkg::OP_PC_EA;
  assign go_cond = accepted && issue.opcode[15:12] == xfer_pkg::OP_SYS_HI
    && issue.opcode[7:0] == xfer_pkg::OP_COND_LO;
  assign go_link = accepted && issue.opcode[15:12] == xfer_pkg::OP_SYS_HI
    && issue.opcode[7:0] == xfer_pkg::OP_LINK_LO;
  assign go_stb = accepted && issue.opcode[15:8] == xfer_pkg::OP_STB_DISP;
  assign go_stl = accepted && issue.opcode[15:12] == xfer_pkg::OP_STL_DISP;
  a_ea_value: assert property (go_ea && !issue.in_delay_slot |=> wb.we
    && wb.index == 4'h0 && wb.data == (prev.pc & xfer_pkg::PC_ALIGN_MASK)
    + xfer_pkg::PC_AHEAD + {22'h0, prev.opcode[7:0], 2'b00})
    else $error("address result wrong");
  a_ea_slot: assert property (go_ea && issue.in_delay_slot |=>
    exc_valid && exc.slot_illegal && !wb.we) else $error("no slot fault");
  a_cond_copy: assert property (go_cond |=> t_we
    && t_value == $past(lk) && !lk) else $error("flag copy wrong");
  a_cond_skip: assert property (go_cond && !lk |=> !mem_req.req)
    else $error("failed store wrote");
  a_cond_store: assert property (go_cond && lk |=> mem_req.req &&
    mem_req.write && mem_req.addr == prev.rn_value
    && mem_req.wdata == prev.r0_value) else $error("store missing");
  a_link_set: assert property (go_link && !event_accepted |=> lk)
    else $error("link not set");
  a_event_clear: assert property (event_accepted |=> !lk)
    else $error("link kept after event");
  a_byte_store: assert property (go_stb |=> mem_req.req &&
    mem_req.size == xfer_pkg::SIZE_BYTE
    && mem_req.addr == prev.rn_value + {28'h0, prev.opcode[3:0]})
    else $error("byte store wrong");
  a_word_store: assert property (go_stl |=> mem_req.req &&
    mem_req.addr == prev.rn_value + {26'h0, prev.opcode[3:0], 2'b00}
    && mem_req.wdata == prev.rm_value) else $error("word store wrong");
  a_fault_no_wb: assert property (mem_rsp.done && mem_rsp.tlb_miss |=>
    exc_valid && !wb.we) else $error("fault not reported");
  a_narrow_stall: assert property (busy && next_reads_r0 && mem_req.req
    && !mem_req.write && mem_req.size != xfer_pkg::SIZE_WORD |-> r0_stall)
    else $error("no stall");
  c_cond_ok: cover property (go_cond && lk);
  c_fault: cover property (mem_rsp.done && mem_rsp.tlb_miss);
  c_stall: cover property (r0_stall);
endmodule

// ### test/testbench.sv
/*
  Self-checking bench for the transfer block with a memory model.
  Assumes the block and package compiled before it.
*/
`timescale 1ns/1ps
module testbench;
  logic clock, rst, next_reads_r0, event_accepted, fault;
  logic accepted, busy, r0_stall, t_we, t_value, exc_valid, link;
  logic got_wb, got_exc, t_val, got_stall;
  logic [3:0] delay;
  logic [7:0] n_writes, k;
  logic [31:0] d;
  int fail_count, n_compared, cycles;
  xfer_pkg::issue_s issue;
  xfer_pkg::mem_req_s mem_req, last_wr;
  xfer_pkg::mem_rsp_s mem_rsp;
  xfer_pkg::wb_s wb, wb_seen;
  xfer_pkg::exc_s exc, exc_seen;
  displacement_move_and_linked_store i_dut (.clock(clock), .rst(rst),
    .issue(issue), .next_reads_r0(next_reads_r0), .busy(busy),
    .event_accepted(event_accepted), .accepted(accepted), .wb(wb),
    .r0_stall(r0_stall), .mem_req(mem_req), .mem_rsp(mem_rsp), .exc(exc),
    .t_we(t_we), .t_value(t_value), .exc_valid(exc_valid),
    .link_reservation_flag(link));
  mem_model i_mem (.clock(clock), .rst(rst), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .delay(delay), .fault(fault), .last_wr(last_wr),
    .n_writes(n_writes));
  // ****
  // Shared tasks
  // ****
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input logic [15:0] op, input logic [31:0] pc, rn, rm,
                     r0, input logic slot);
    @(posedge clock); #1;
    issue = '{1'b1, op, pc, slot, rn, rm, r0};
    {got_wb, got_exc, t_val, got_stall} = 4'h0;
    wb_seen = '0;
    exc_seen = '0;
    @(posedge clock); #1;
    issue.valid = 1'b0;
    repeat (12) begin
      if (wb.we === 1'b1) {got_wb, wb_seen} = {1'b1, wb};
      if (exc_valid === 1'b1) {got_exc, exc_seen} = {1'b1, exc};
      if (t_we === 1'b1) t_val = t_value;
      if (r0_stall === 1'b1) got_stall = 1'b1;
      @(posedge clock); #1;
    end
  endtask
  task automatic check_wb(input logic [3:0] idx, input logic [31:0] data);
    check("wb seen", got_wb, 1'b1);
    check("wb index", wb_seen.index, idx);
    check("wb data", wb_seen.data, data);
  endtask
  task automatic report_and_stop();
    $display("Compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_stores();
    logic [15:0] ops [3] = '{16'h807F, 16'h815F, 16'h1A6F};
    logic [31:0] msk [3] = '{32'hFF, 32'hFFFF, 32'hFFFFFFFF};
    for (int i = 0; i < 3; i++) begin
      run(ops[i], 32'h0, 32'h4000, 32'h12345678, 32'hCAFEBEEF, 1'b0);
      check("st addr", last_wr.addr, 32'h4000 + (32'hF << i));
      check("st data", last_wr.wdata & msk[i],
            (i == 2 ? 32'h12345678 : 32'hCAFEBEEF) & msk[i]);
    end
    $display("test stores done");
  endtask
  task automatic t_loads();
    delay = 4'h3;
    next_reads_r0 = 1'b1;
    run(16'h8413, 32'h0, 32'h0, 32'h1000, 32'h0, 1'b0);
    d = ~32'h1003;
    check_wb(4'h0, {{24{d[7]}}, d[7:0]});
    check("stall", got_stall, 1'b1);
    run(16'h8525, 32'h0, 32'h0, 32'h2000, 32'h0, 1'b0);
    d = ~32'h200A;
    check_wb(4'h0, {{16{d[15]}}, d[15:0]});
    next_reads_r0 = 1'b0;
    run(16'h5936, 32'h0, 32'h0, 32'h3000, 32'h0, 1'b0);
    check_wb(4'h9, ~32'h3018);
    delay = 4'h0;
    $display("test loads done");
  endtask
  task automatic t_ea();
    run(16'hC702, 32'h1006, 32'h0, 32'h0, 32'h0, 1'b0);
    check_wb(4'h0, 32'h1010);
    run(16'hC7FF, 32'h2003, 32'h0, 32'h0, 32'h0, 1'b0);
    check_wb(4'h0, 32'h2400);
    run(16'hC702, 32'h1006, 32'h0, 32'h0, 32'h0, 1'b1);
    check("slot exc", {got_exc, got_wb, exc_seen.slot_illegal}, 3'b101);
    $display("test address done");
  endtask
  task automatic t_alloc();
    run(16'h04C3, 32'h0, 32'h5008, 32'h0, 32'h89ABCDEF, 1'b0);
    check("alloc addr", last_wr.addr, 32'h5008);
    check("alloc data", last_wr.wdata, 32'h89ABCDEF);
    check("alloc flag", last_wr.alloc, 1'b1);
    $display("test alloc done");
  endtask
  task automatic t_link();
    run(16'h0663, 32'h0, 32'h6000, 32'h6000, 32'h0, 1'b0);
    check_wb(4'h0, ~32'h6000);
    check("link set", link, 1'b1);
    k = n_writes;
    run(16'h0673, 32'h0, 32'h6000, 32'h6000, 32'h77, 1'b0);
    check("t ok", t_val, 1'b1);
    check("cond count", n_writes, k + 8'h01);
    check("cond data", last_wr.wdata, 32'h77);
    check("link clr", link, 1'b0);
    run(16'h0673, 32'h0, 32'h6000, 32'h6000, 32'h55, 1'b0);
    check("t fail", {t_val, n_writes}, {1'b0, k + 8'h01});
    run(16'h0663, 32'h0, 32'h6000, 32'h6000, 32'h0, 1'b0);
    event_accepted = 1'b1;
    @(posedge clock); #1;
    event_accepted = 1'b0;
    run(16'h0673, 32'h0, 32'h6000, 32'h6000, 32'h55, 1'b0);
    check("t event", {t_val, n_writes}, {1'b0, k + 8'h01});
    $display("test link done");
  endtask
  task automatic t_fault();
    fault = 1'b1;
    k = n_writes;
    run(16'h1A6F, 32'h0, 32'h4000, 32'h1, 32'h0, 1'b0);
    check("st fault", {got_exc, got_wb, n_writes}, {2'b10, k});
    run(16'h5936, 32'h0, 32'h0, 32'h3000, 32'h0, 1'b0);
    check("ld fault", {got_exc, got_wb}, 2'b10);
    run(16'h0663, 32'h0, 32'h6000, 32'h6000, 32'h0, 1'b0);
    check("link exc", link, 1'b0);
    fault = 1'b0;
    $display("test fault done");
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    cycles = 0;
    forever begin
      @(posedge clock);
      cycles++;
      if (cycles == 4000) begin
        fail_count++;
        report_and_stop();
      end
    end
  end
  initial begin
    {rst, next_reads_r0, event_accepted, fault, delay} = 8'h00;
    rst = 1'b1;
    issue = '0;
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    t_stores();
    t_loads();
    t_ea();
    t_alloc();
    t_link();
    t_fault();
    report_and_stop();
  end
endmodule
bind displacement_move_and_linked_store xfer_checker i_chk (.clock(clock),
  .rst(rst), .issue(issue), .next_reads_r0(next_reads_r0), .busy(busy),
  .event_accepted(event_accepted), .accepted(accepted), .wb(wb),
  .r0_stall(r0_stall), .mem_req(mem_req), .mem_rsp(mem_rsp), .exc(exc),
  .t_we(t_we), .t_value(t_value), .exc_valid(exc_valid),
  .link_reservation_flag(link_reservation_flag));
